// file: hdl/tsc_pkg.sv
// Shared constants and types for the temperature sensor serial port
package tsc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 25000;
  localparam int PERIOD_TIME_NS = 400000;
  // Shortest-time rounding: whole cycles, floored, never below one
  localparam int CONV_CYC_INT = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int PERIOD_CYC_INT = PERIOD_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONV_CYC_INT);
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam int TEMP_W = 10;
  localparam int FRAME_BITS = 16;
  localparam int PAD_W = FRAME_BITS - TEMP_W;
  localparam logic [TEMP_W-1:0] TEMP_RST = 10'h000;
  localparam logic [PAD_W-1:0] PAD_BITS = 6'h00;
  localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
  localparam int FALL_W = 5;
  localparam logic [FALL_W-1:0] FALL_ZERO = 5'h00;
  localparam logic [FALL_W-1:0] FALL_ONE = 5'h01;
  localparam logic [FALL_W-1:0] FALL_LAST = 5'h10;
  localparam logic [FALL_W-1:0] FALL_BEFORE_COMMIT = 5'h0E;
  localparam logic [1:0] RISE_ZERO = 2'h0;
  localparam logic [1:0] RISE_ONE = 2'h1;
  localparam logic [1:0] RISE_SD_BIT = 2'h2;
  localparam logic [1:0] RISE_MAX = 2'h3;
  typedef enum logic [1:0] {
    TSC_SHUT,
    TSC_CONV,
    TSC_PUSH,
    TSC_WAIT
  } tsc_state_e;
endpackage : tsc_pkg

// file: hdl/tsc_stream_if.sv
// Valid/ready stream carrying one temperature result word
`timescale 1ns/1ns
interface tsc_stream_if;
  import tsc_pkg::*;
  logic valid;
  logic ready;
  logic [TEMP_W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface : tsc_stream_if

// file: hdl/tsc_fifo.sv
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ns
module tsc_fifo
  import tsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  tsc_stream_if.rx in_s,
  tsc_stream_if.tx out_s
);
  localparam int DEPTH = 2;
  logic [TEMP_W-1:0] mem_reg [DEPTH];
  logic [TEMP_W-1:0] mem_next [DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;
  logic push, pop;

  assign in_s.ready = (count_reg != 2'h2);
  assign out_s.valid = (count_reg != 2'h0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_comb begin
        mem_next[g] = mem_reg[g];
        if (push && (wr_ptr_reg == 1'(g))) begin
          mem_next[g] = in_s.data;
        end
      end
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          mem_reg[g] <= TEMP_RST;
        end else begin
          mem_reg[g] <= mem_next[g];
        end
      end
    end
  endgenerate

  always_comb begin
    wr_ptr_next = push ? ~wr_ptr_reg : wr_ptr_reg;
    rd_ptr_next = pop ? ~rd_ptr_reg : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end
endmodule : tsc_fifo

// file: hdl/tsc_top.sv
// Temperature sensor conversion sequencer and serial port
// How it works
// - Serial logic held in reset while select is high; clock ignored.
// - Data input sampled on the third rising serial clock edge while selected.
// - Result bits change on the data output at each falling clock edge.
// - Conversions timed by the local clock, never by the serial clock.
// - A new conversion starts every 400 us in normal mode.
// - Conversion lasts 25 us, then the converter is powered down.
// - Latest completed result sits in a holding register, readable anytime.
// - Shutdown stops the timer; no conversion starts until it clears.
// - Holding register keeps the last result throughout shutdown.
// - End of a transfer outside shutdown restarts timing and starts a conversion, except while a result waits to be pushed.
// - Leaving shutdown restarts timing and starts a conversion at once.
// - A read before the pending conversion ends returns the old result.
// - Result is the 10-bit code from the successive-approximation core.
// - Sixteen clocks per frame; last bit held, then output released.
// - Ten-bit two's complement result sent MSB first.
// - Third incoming bit requests shutdown; first two are ignored.
// - Control commits on fifteenth falling edge; early deselect aborts.
`timescale 1ns/1ns
module tsc_top
  import tsc_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(PERIOD_CYC_INT)
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic DIN_I,
  output logic DOUT_O,
  output logic DOUT_OE_O,
  input wire logic [TEMP_W-1:0] ADC_CODE_I,
  output logic ADC_EN_O,
  output logic SHUTDOWN_O
);
  // Link domain: serial clock, cleared asynchronously by deselect
  logic [1:0] rise_cnt_reg, rise_cnt_next;
  logic sd_bit_reg, sd_bit_next;
  logic [FALL_W-1:0] fall_cnt_reg, fall_cnt_next;
  logic [FRAME_BITS-1:0] sh_reg, sh_next;
  logic commit_on_reg, commit_on_next;
  logic commit_off_reg, commit_off_next;
  logic [TEMP_W-1:0] hold_reg, hold_next;

  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    sd_bit_next = sd_bit_reg;
    if (rise_cnt_reg != RISE_MAX) begin
      rise_cnt_next = rise_cnt_reg + RISE_ONE;
    end
    if (rise_cnt_reg == RISE_SD_BIT) begin
      sd_bit_next = DIN_I;
    end
  end

  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      rise_cnt_reg <= RISE_ZERO;
      sd_bit_reg <= 1'b0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      sd_bit_reg <= sd_bit_next;
    end
  end

  always_comb begin
    fall_cnt_next = fall_cnt_reg;
    sh_next = sh_reg;
    commit_on_next = commit_on_reg;
    commit_off_next = commit_off_reg;
    if (fall_cnt_reg == FALL_ZERO) begin
      // Holding register is frozen while selected, so it is stable here
      sh_next = {hold_reg, PAD_BITS};
    end else if (fall_cnt_reg != FALL_LAST) begin
      sh_next = {sh_reg[FRAME_BITS-2:0], 1'b0};
    end
    if (fall_cnt_reg != FALL_LAST) begin
      fall_cnt_next = fall_cnt_reg + FALL_ONE;
    end
    if (fall_cnt_reg == FALL_BEFORE_COMMIT) begin
      commit_on_next = sd_bit_reg;
      commit_off_next = !sd_bit_reg;
    end
  end

  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      fall_cnt_reg <= FALL_ZERO;
      sh_reg <= SHIFT_RST;
      commit_on_reg <= 1'b0;
      commit_off_reg <= 1'b0;
    end else begin
      fall_cnt_reg <= fall_cnt_next;
      sh_reg <= sh_next;
      commit_on_reg <= commit_on_next;
      commit_off_reg <= commit_off_next;
    end
  end

  // After the sixteenth fall the shifter stops, holding bit zero
  assign DOUT_O = sh_reg[FRAME_BITS-1];
  assign DOUT_OE_O = !CS_N_I;

  // Crossing into the local clock: levels through two flops each
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic on_s1_reg, on_s2_reg, on_s3_reg;
  logic off_s1_reg, off_s2_reg, off_s3_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      on_s1_reg <= 1'b0;
      on_s2_reg <= 1'b0;
      on_s3_reg <= 1'b0;
      off_s1_reg <= 1'b0;
      off_s2_reg <= 1'b0;
      off_s3_reg <= 1'b0;
    end else begin
      cs_s1_reg <= CS_N_I;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      on_s1_reg <= commit_on_reg;
      on_s2_reg <= on_s1_reg;
      on_s3_reg <= on_s2_reg;
      off_s1_reg <= commit_off_reg;
      off_s2_reg <= off_s1_reg;
      off_s3_reg <= off_s2_reg;
    end
  end

  logic busy, xfer_end, go_shut, go_run;
  assign busy = !cs_s2_reg;
  assign xfer_end = cs_s2_reg && !cs_s3_reg;
  assign go_shut = on_s2_reg && !on_s3_reg;
  assign go_run = off_s2_reg && !off_s3_reg;

  // Conversion sequencer on the local clock
  tsc_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [TEMP_W-1:0] res_reg, res_next;
  logic sd_reg, sd_next;
  logic conv_done;

  tsc_stream_if in_s ();
  tsc_stream_if out_s ();

  assign conv_done = (state_reg == TSC_CONV) &&
                     (cnt_reg == CONV_CYC - CNT_ONE);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + CNT_ONE;
    res_next = res_reg;
    sd_next = sd_reg;
    unique case (state_reg)
      TSC_SHUT: begin
        cnt_next = CNT_ZERO;
      end
      TSC_CONV: begin
        if (conv_done) begin
          res_next = ADC_CODE_I;
          state_next = TSC_PUSH;
        end
      end
      TSC_PUSH: begin
        // Full buffer stalls here; the timer keeps running meanwhile
        if (in_s.ready) begin
          state_next = TSC_WAIT;
        end
      end
      TSC_WAIT: begin
        if (cnt_reg >= PERIOD_CYC - CNT_ONE) begin
          state_next = TSC_CONV;
          cnt_next = CNT_ZERO;
        end
      end
    endcase
    if (xfer_end && !sd_reg && state_reg != TSC_PUSH) begin
      state_next = TSC_CONV;
      cnt_next = CNT_ZERO;
    end
    if (go_run && sd_reg) begin
      sd_next = 1'b0;
      state_next = TSC_CONV;
      cnt_next = CNT_ZERO;
    end
    if (go_shut) begin
      sd_next = 1'b1;
      state_next = TSC_SHUT;
      cnt_next = CNT_ZERO;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state_reg <= TSC_CONV;
      cnt_reg <= CNT_ZERO;
      res_reg <= TEMP_RST;
      sd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      sd_reg <= sd_next;
    end
  end

  assign in_s.valid = (state_reg == TSC_PUSH);
  assign in_s.data = res_reg;

  tsc_fifo u_fifo (
    .clk_i (CLK_I),
    .rst_n_i (RESETN_I),
    .in_s (in_s),
    .out_s (out_s)
  );

  // Drain stalls while selected so a word in flight is never altered
  // Only the settled select is read; the first flop may be metastable
  assign out_s.ready = !busy;

  always_comb begin
    hold_next = hold_reg;
    if (out_s.valid && out_s.ready) begin
      hold_next = out_s.data;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      hold_reg <= TEMP_RST;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign ADC_EN_O = (state_reg == TSC_CONV);
  assign SHUTDOWN_O = sd_reg;
endmodule : tsc_top

// file: tb/tsc_monitor.sv
// Concurrent checks on the sensor serial port top
`timescale 1ns/1ns
module tsc_monitor
  import tsc_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERIOD_CYC = 13'h1F40
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CS_N_I,
  input wire logic DOUT_OE_O,
  input wire logic ADC_EN_O,
  input wire logic SHUTDOWN_O
);
  logic [CNT_W-1:0] on_reg, on_next, gap_reg, gap_next;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  always_comb begin
    on_next = ADC_EN_O ? on_reg + CNT_ONE : CNT_ZERO;
    gap_next = (ADC_EN_O | SHUTDOWN_O) ? CNT_ZERO : gap_reg + CNT_ONE;
  end
  always_ff @(posedge CLK_I) begin
    on_reg <= RESETN_I ? on_next : CNT_ZERO;
    gap_reg <= RESETN_I ? gap_next : CNT_ZERO;
  end
  sequence s_leave;
    SHUTDOWN_O ##1 !SHUTDOWN_O;
  endsequence
  a_oe_follows_cs: assert property (DOUT_OE_O == !CS_N_I)
    else $error("enable differs from select");
  a_reset_starts: assert property ($rose(RESETN_I) |-> ADC_EN_O)
    else $error("no conversion after reset");
  // Slack of four covers a count held or run during reset
  a_conv_length: assert property (
    $fell(ADC_EN_O) && on_reg < CONV_CYC - 13'h0004 |-> ##[0:3] SHUTDOWN_O)
    else $error("conversion ended early");
  a_no_conv_shut: assert property (SHUTDOWN_O [*3] |-> !ADC_EN_O)
    else $error("conversion while shut down");
  a_leave_shut: assert property (s_leave |-> ##[0:4] ADC_EN_O)
    else $error("no conversion after wake");
  a_cs_restart: assert property (
    $rose(CS_N_I) && !SHUTDOWN_O |-> ##[1:6] ADC_EN_O)
    else $error("no conversion after transfer");
  a_shut_steady: assert property (CS_N_I [*8] |-> $stable(SHUTDOWN_O))
    else $error("shutdown changed while idle");
  a_period_due: assert property (
    gap_reg <= PERIOD_CYC - CONV_CYC + 13'h0002)
    else $error("periodic conversion missing");
endmodule : tsc_monitor
bind tsc_top tsc_monitor #(.PERIOD_CYC(PERIOD_CYC)) mon_u (.CLK_I(CLK_I),
  .RESETN_I(RESETN_I), .CS_N_I(CS_N_I), .DOUT_OE_O(DOUT_OE_O),
  .ADC_EN_O(ADC_EN_O), .SHUTDOWN_O(SHUTDOWN_O));

// file: tb/tsc_host_model.sv
// Serial master model for the sensor port
`timescale 1ns/1ns
module tsc_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // Released line reads as high impedance, so a late bit cannot pass
  wire dout_w = dout_oe_i ? dout_i : 1'bz;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b1;
  end
  // Clock runs only inside frames and idles high
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'hFFFF;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    #200;
    for (int k = 0; k < n; k++) begin
      sclk_o = 1'b0;
      din_o = tx[15-k];
      #3 sclk_o = 1'b1;
      rx[15-k] = dout_w;
      #3;
    end
    #300;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    din_o = ~din_o;
    #250;
  endtask : frame
endmodule : tsc_host_model

// file: tb/testbench.sv
// Self-checking bench for the sensor serial port
`timescale 1ns/1ns
module testbench;
  import tsc_pkg::*;
  localparam logic [CNT_W-1:0] PER = 13'h04B0;
  logic clk, rst_n, sclk, cs_n, din, dout, oe, en, shut;
  logic [TEMP_W-1:0] code;
  logic [15:0] rx;
  int err_count, comparisons, n, hi, lo;
  tsc_top #(.PERIOD_CYC(PER)) dut_u (.CLK_I(clk), .RESETN_I(rst_n),
    .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .DOUT_O(dout),
    .DOUT_OE_O(oe), .ADC_CODE_I(code), .ADC_EN_O(en), .SHUTDOWN_O(shut));
  tsc_host_model host_u (.clk_i(clk), .dout_i(dout), .dout_oe_i(oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_en(logic lv, output int c);
    c = 0;
    while (en !== lv && c < 3000) begin
      @(negedge clk);
      c++;
    end
    if (c == 3000) chk("wait", 16'h0000, 16'hFFFF);
  endtask : wait_en
  task automatic conv;
    wait_en(1'b1, n);
    wait_en(1'b0, n);
    repeat (8) @(negedge clk);
  endtask : conv
  task automatic t_read;
    logic [TEMP_W-1:0] v[3] = '{10'h064, 10'h3FF, 10'h200};
    foreach (v[i]) begin
      code = v[i];
      conv;
      host_u.frame(16'h0000, 16, rx);
      chk("word", {v[i], PAD_BITS}, rx);
      chk("enable", 16'h0000, {15'h0000, oe});
    end
    $display("t_read end");
  endtask : t_read
  task automatic t_stale;
    code = 10'h1FC;
    host_u.frame(16'h0000, 16, rx);
    chk("stale", {10'h200, PAD_BITS}, rx);
    conv;
    host_u.frame(16'h0000, 16, rx);
    chk("fresh", {10'h1FC, PAD_BITS}, rx);
    $display("t_stale end");
  endtask : t_stale
  task automatic t_shut;
    host_u.frame(16'hE000, 16, rx);
    chk("shut on", 16'h0001, {15'h0000, shut});
    code = 10'h0C8;
    repeat (1300) @(negedge clk);
    chk("idle", 16'h0000, {15'h0000, en});
    host_u.frame(16'h0000, 14, rx);
    chk("held", {10'h1FC, 6'h03}, rx);
    chk("shut kept", 16'h0001, {15'h0000, shut});
    host_u.frame(16'hC000, 16, rx);
    chk("shut off", 16'h0000, {15'h0000, shut});
    conv;
    host_u.frame(16'h0000, 16, rx);
    chk("wake", {10'h0C8, PAD_BITS}, rx);
    $display("t_shut end");
  endtask : t_shut
  task automatic t_period;
    wait_en(1'b1, n);
    wait_en(1'b0, n);
    wait_en(1'b1, lo);
    wait_en(1'b0, hi);
    wait_en(1'b1, lo);
    chk("conv", 16'(CONV_CYC), 16'(hi));
    chk("period", 16'(PER), 16'(hi + lo));
    $display("t_period end");
  endtask : t_period
  task automatic end_sim;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    code = 10'h000;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_read;
    t_stale;
    t_shut;
    t_period;
    end_sim;
  end
  // Whole run needs well under 20000 cycles
  initial begin
    #1000000;
    err_count++;
    end_sim;
  end
endmodule : testbench
